// [src/serial_unit_consts.svh]
/*
 Offsets, field positions, reset values and timing counts
 of the serial unit. Assumes inclusion by bare name.
*/
`ifndef SERIAL_UNIT_CONSTS_SVH
`define SERIAL_UNIT_CONSTS_SVH
// Register offsets
`define OFS_FORMAT 3'h0
`define OFS_CTRL 3'h2
`define OFS_TXH 3'h3
`define OFS_FLAG 3'h4
`define OFS_RXH 3'h5
// Format register fields
`define FMT_SYNC 7
`define FMT_SEVEN 6
`define FMT_PAR_EN 5
`define FMT_ODD 4
`define FMT_TWO_STOP 3
`define FMT_MP 2
// Control register fields
`define CTL_TX_EN 5
`define CTL_RX_EN 4
`define CTL_MPB_TX 0
// Flag register fields
`define FLG_TXE 7
`define FLG_RXF 6
`define FLG_ORER 5
`define FLG_FER 4
`define FLG_PER 3
`define FLG_TX_IDLE 2
`define FLG_MPB_RX 1
// Reset values
`define RST_FORMAT 8'h00
`define RST_TXH 8'hFF
`define RST_RXH 8'h00
// Timing
`define PRESCALE_BASE 16'h0004
`define OVS_LAST 4'hF
`define OVS_MID 4'h7
`define SYNC_LAST 4'h1
`endif

// [src/serial_unit_pkg.sv]
/*
 Types of the serial unit: state codes and state records.
 Assumes the constants header for field layouts.
*/
package serial_unit_pkg;
  // Transmit engine states
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_RUN = 1'b1
  } tx_state_type;
  // Receive engine states
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10
  } rx_state_type;
  // Baud timer state
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } timer_type;
  // Serial unit state
  typedef struct packed {
    logic [7:0] fmt;
    logic [7:0] txh;
    logic [7:0] rxh;
    logic txe;
    logic rxf;
    logic orer;
    logic fer;
    logic per;
    logic mpb_rx;
    logic ten;
    logic ren;
    logic mpb_tx;
    logic [7:0] rdata;
    tx_state_type tx_st;
    logic [11:0] tx_sh;
    logic [3:0] tx_left;
    logic [3:0] tx_ph;
    logic txd;
    logic sck;
    logic rx_m1;
    logic rx_m2;
    rx_state_type rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_idx;
    logic [3:0] rx_ph;
    logic rx_par;
  } core_type;
endpackage

// [src/serial_baud_timer.sv]
/*
 Baud timer: one-cycle tick every prescale*BIT_DIV clocks.
 Assumes a single clock; clear is a same-clock level.
*/
`timescale 1ns/10ps
`include "serial_unit_consts.svh"
module serial_baud_timer #(
  parameter logic [7:0] BIT_DIV = 8'h01
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic [1:0] sel,
  output logic tick
);
  // Tick spacing less one, from the prescale choice
  function automatic logic [15:0] limit(input logic [1:0] s);
    logic [15:0] p;
    p = `PRESCALE_BASE << {s, 1'b0};
    return 16'(p * {8'h00, BIT_DIV}) - 16'h0001;
  endfunction

  serial_unit_pkg::timer_type tm_ff;
  serial_unit_pkg::timer_type nxt_tm;

  // Next count and tick
  always_comb begin
    nxt_tm = tm_ff;
    nxt_tm.tick = 1'b0;
    if (clear) begin
      nxt_tm.cnt = 16'h0000;
    end else if (tm_ff.cnt >= limit(sel)) begin
      // Divide by 4, 16, 64 or 256
      nxt_tm.cnt = 16'h0000;
      nxt_tm.tick = 1'b1;
    end else begin
      nxt_tm.cnt = tm_ff.cnt + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tm_ff <= '0;
    end else begin
      tm_ff <= nxt_tm;
    end
  end

  assign tick = tm_ff.tick;
endmodule

// [src/serial_unit.sv]
/*
 Serial unit data path and frame format: holding and shift
 registers, format register, async and clocked sync engines.
 Assumes a same-clock register port and a pin-level rxd.
*/
// Added by the designer: the register addresses and the strobed register port.
// Summary of operation
// - Receive bits enter shift register LSB first
// - Completed byte moves to holding register automatically
// - Shift registers are hidden from software
// - Receive holding reads only, clears on reset/standby
// - Empty shift register loads holding, sends LSB first
// - Next byte loads unless holding-empty flag set
// - Transmit holding read/write, resets to FF
// - Format register read/write, resets to 00
// - Format bit 7 picks async or sync
// - Bit 6 picks seven bits, async only
// - Seven-bit frames drop holding bit 7
// - Bit 5 enables parity, async only
// - Bit 4 picks even or odd parity
// - Bit 3 picks one or two stops
// - Receiver checks first stop only
// - Bit 2 multiprocessor format overrides parity
// - Bits 1:0 pick clock divide 4..256
// - Holding written during send gives no gap
// - Load into shift register sets holding-empty
// - Clearing holding-empty starts transmission
// - Move into receive holding sets full flag
`timescale 1ns/10ps
`include "serial_unit_consts.svh"
module serial_unit #(
  parameter logic [7:0] BIT_DIV = 8'h01
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic standby,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic rxd,
  output logic txd,
  output logic sck_out,
  output logic tx_holding_empty_flag,
  output logic rx_holding_full_flag
);
  // Data bits of a character
  function automatic logic [3:0] data_len(input logic [7:0] f);
    return (!f[`FMT_SYNC] && f[`FMT_SEVEN]) ? 4'h7 : 4'h8;
  endfunction

  // Parity or multiprocessor bit present
  function automatic logic has_extra(input logic [7:0] f);
    return !f[`FMT_SYNC] && (f[`FMT_PAR_EN] || f[`FMT_MP]);
  endfunction

  // Parity check active, multiprocessor overrides
  function automatic logic par_on(input logic [7:0] f);
    return !f[`FMT_SYNC] && f[`FMT_PAR_EN] && !f[`FMT_MP];
  endfunction

  // Reset and standby values
  function automatic serial_unit_pkg::core_type rst_state();
    serial_unit_pkg::core_type s;
    s = '0;
    s.fmt = `RST_FORMAT;
    s.txh = `RST_TXH;
    s.rxh = `RST_RXH;
    s.txe = 1'b1;
    s.txd = 1'b1;
    s.sck = 1'b1;
    s.rx_m1 = 1'b1;
    s.rx_m2 = 1'b1;
    s.tx_st = serial_unit_pkg::TX_IDLE;
    s.rx_st = serial_unit_pkg::RX_IDLE;
    return s;
  endfunction

  localparam serial_unit_pkg::core_type CORE_RST = rst_state();

  serial_unit_pkg::core_type st_ff;
  serial_unit_pkg::core_type nxt_st;
  logic tick; // Baud enable pulse
  logic tx_load; // Shift register loaded from holding
  logic tx_fin; // Last bit of a frame ends
  logic rx_move; // Received byte offered to holding
  logic sck_rise; // Sync clock rising edge
  logic [3:0] len; // Data bits now selected
  logic [3:0] last_ph; // Ticks per bit less one
  logic [11:0] frame; // Frame built for the shift register
  logic [3:0] flen; // Frame length in bits
  logic pbit; // Parity or multiprocessor bit
  logic [7:0] dmask; // Holding data as sent

  // Baud tick source, prescale from format bits 1:0
  serial_baud_timer #(.BIT_DIV(BIT_DIV)) u_timer (
    .clk(clk),
    .rst(rst),
    .clear(standby),
    .sel(st_ff.fmt[1:0]),
    .tick(tick)
  );

  // Next-state logic of the whole unit
  always_comb begin
    nxt_st = st_ff;
    tx_load = 1'b0;
    rx_move = 1'b0;
    len = data_len(st_ff.fmt);
    last_ph = st_ff.fmt[`FMT_SYNC] ? `SYNC_LAST : `OVS_LAST;
    // Seven-bit frames drop bit 7
    dmask = (len == 4'h7) ? {1'b0, st_ff.txh[6:0]} : st_ff.txh;
    // Even or odd sense or multiprocessor bit
    pbit = st_ff.fmt[`FMT_MP] ? st_ff.mpb_tx : (^dmask) ^ st_ff.fmt[`FMT_ODD];
    frame = 12'hFFF;
    if (st_ff.fmt[`FMT_SYNC]) begin
      // Sync: eight bits, no start, stop or parity
      frame[7:0] = st_ff.txh;
      flen = 4'h8;
    end else begin
      // Async: start, data LSB first, extra bit, stops
      frame[0] = 1'b0;
      frame[8:1] = dmask;
      if (len == 4'h7) begin
        frame[8] = has_extra(st_ff.fmt) ? pbit : 1'b1;
      end else begin
        frame[9] = has_extra(st_ff.fmt) ? pbit : 1'b1;
      end
      // One or two stop bits
      flen = 4'(4'h2 + len + {3'h0, has_extra(st_ff.fmt)} + {3'h0, st_ff.fmt[`FMT_TWO_STOP]});
    end
    // Double-flop the receive pin
    nxt_st.rx_m1 = rxd;
    nxt_st.rx_m2 = st_ff.rx_m1;

    // Register port; shift registers have no address
    nxt_st.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        `OFS_FORMAT: nxt_st.rdata = st_ff.fmt;
        `OFS_TXH: nxt_st.rdata = st_ff.txh;
        `OFS_RXH: nxt_st.rdata = st_ff.rxh;
        `OFS_CTRL: begin
          nxt_st.rdata[`CTL_TX_EN] = st_ff.ten;
          nxt_st.rdata[`CTL_RX_EN] = st_ff.ren;
          nxt_st.rdata[`CTL_MPB_TX] = st_ff.mpb_tx;
        end
        `OFS_FLAG: begin
          nxt_st.rdata[`FLG_TXE] = st_ff.txe;
          nxt_st.rdata[`FLG_RXF] = st_ff.rxf;
          nxt_st.rdata[`FLG_ORER] = st_ff.orer;
          nxt_st.rdata[`FLG_FER] = st_ff.fer;
          nxt_st.rdata[`FLG_PER] = st_ff.per;
          nxt_st.rdata[`FLG_TX_IDLE] = (st_ff.tx_st == serial_unit_pkg::TX_IDLE);
          nxt_st.rdata[`FLG_MPB_RX] = st_ff.mpb_rx;
        end
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    if (wr) begin
      unique case (addr)
        `OFS_FORMAT: nxt_st.fmt = wdata;
        `OFS_TXH: nxt_st.txh = wdata;
        `OFS_CTRL: begin
          nxt_st.ten = wdata[`CTL_TX_EN];
          nxt_st.ren = wdata[`CTL_RX_EN];
          nxt_st.mpb_tx = wdata[`CTL_MPB_TX];
        end
        `OFS_FLAG: begin
          // Flags clear by writing 0; writing 1 keeps them
          nxt_st.txe = st_ff.txe & wdata[`FLG_TXE];
          nxt_st.rxf = st_ff.rxf & wdata[`FLG_RXF];
          nxt_st.orer = st_ff.orer & wdata[`FLG_ORER];
          nxt_st.fer = st_ff.fer & wdata[`FLG_FER];
          nxt_st.per = st_ff.per & wdata[`FLG_PER];
        end
        default: begin
          // Receive holding and unmapped: writes ignored
        end
      endcase
    end

    // Transmit engine
    sck_rise = (st_ff.tx_st == serial_unit_pkg::TX_RUN) && tick && st_ff.fmt[`FMT_SYNC] && st_ff.tx_ph == 4'h0;
    tx_fin = (st_ff.tx_st == serial_unit_pkg::TX_RUN) && tick && st_ff.tx_ph == last_ph && st_ff.tx_left == 4'h1;
    if ((st_ff.tx_st == serial_unit_pkg::TX_RUN) && tick) begin
      if (st_ff.tx_ph == last_ph) begin
        // Bit ends: shift out the next one
        nxt_st.tx_ph = 4'h0;
        nxt_st.tx_sh = {1'b1, st_ff.tx_sh[11:1]};
        nxt_st.txd = st_ff.tx_sh[1];
        nxt_st.tx_left = st_ff.tx_left - 4'h1;
        nxt_st.sck = st_ff.fmt[`FMT_SYNC] ? 1'b0 : 1'b1;
        if (tx_fin) begin
          nxt_st.tx_st = serial_unit_pkg::TX_IDLE;
          nxt_st.txd = 1'b1;
          nxt_st.sck = 1'b1;
        end
      end else begin
        nxt_st.tx_ph = st_ff.tx_ph + 4'h1;
        if (sck_rise) begin
          nxt_st.sck = 1'b1;
        end
      end
    end
    // Load when idle or at frame end, only with flag at 0
    if (st_ff.ten && !st_ff.txe && ((st_ff.tx_st == serial_unit_pkg::TX_IDLE) || tx_fin)) begin
      tx_load = 1'b1; // Back to back, no idle bit
      nxt_st.tx_sh = frame;
      nxt_st.txd = frame[0];
      nxt_st.tx_left = flen;
      nxt_st.tx_ph = 4'h0;
      nxt_st.tx_st = serial_unit_pkg::TX_RUN;
      nxt_st.sck = !st_ff.fmt[`FMT_SYNC];
      nxt_st.txe = 1'b1; // Set wins over a clear
      nxt_st.rx_idx = 4'h0;
    end else if (st_ff.fmt[`FMT_SYNC] && st_ff.ren && !st_ff.ten && !st_ff.rxf
                 && st_ff.tx_st == serial_unit_pkg::TX_IDLE) begin
      // Receive-only sync: run the clock, line stays high
      nxt_st.tx_sh = 12'hFFF;
      nxt_st.tx_left = 4'h8;
      nxt_st.tx_ph = 4'h0;
      nxt_st.tx_st = serial_unit_pkg::TX_RUN;
      nxt_st.sck = 1'b0;
      nxt_st.rx_idx = 4'h0;
    end
    // Holding empty is held at 1 while transmitter is off
    if (!nxt_st.ten) begin
      nxt_st.txe = 1'b1;
    end

    // Receive engine
    if (st_ff.fmt[`FMT_SYNC]) begin
      nxt_st.rx_st = serial_unit_pkg::RX_IDLE;
      if (sck_rise && st_ff.ren) begin
        // Sample on rising clock, LSB first
        nxt_st.rx_sh[st_ff.rx_idx[2:0]] = st_ff.rx_m2;
        nxt_st.rx_idx = st_ff.rx_idx + 4'h1;
        if (st_ff.rx_idx == 4'h7) begin
          rx_move = 1'b1;
        end
      end
    end else begin
      unique case (st_ff.rx_st)
        serial_unit_pkg::RX_IDLE: begin
          // Falling line is a start bit
          if (st_ff.ren && !st_ff.rx_m2) begin
            nxt_st.rx_st = serial_unit_pkg::RX_START;
            nxt_st.rx_ph = 4'h0;
          end
        end
        serial_unit_pkg::RX_START: begin
          if (tick) begin
            nxt_st.rx_ph = st_ff.rx_ph + 4'h1;
            if (st_ff.rx_ph == `OVS_MID) begin
              // Still low at mid-bit: genuine start
              nxt_st.rx_st = st_ff.rx_m2 ? serial_unit_pkg::RX_IDLE : serial_unit_pkg::RX_DATA;
              nxt_st.rx_ph = 4'h0;
              nxt_st.rx_idx = 4'h0;
              nxt_st.rx_par = 1'b0;
              nxt_st.rx_sh = 8'h00; // Bit 7 stays 0 for seven bits
            end
          end
        end
        serial_unit_pkg::RX_DATA: begin
          if (tick) begin
            nxt_st.rx_ph = st_ff.rx_ph + 4'h1;
            if (st_ff.rx_ph == `OVS_LAST) begin
              nxt_st.rx_idx = st_ff.rx_idx + 4'h1;
              if (st_ff.rx_idx < len) begin
                // Data bit, LSB first
                nxt_st.rx_sh[st_ff.rx_idx[2:0]] = st_ff.rx_m2;
                nxt_st.rx_par = st_ff.rx_par ^ st_ff.rx_m2;
              end else if (st_ff.rx_idx == len && has_extra(st_ff.fmt)) begin
                nxt_st.rx_par = st_ff.rx_par ^ st_ff.rx_m2;
                if (st_ff.fmt[`FMT_MP]) begin
                  nxt_st.mpb_rx = st_ff.rx_m2;
                end
              end else begin
                // First stop only; second is never looked at
                nxt_st.rx_st = serial_unit_pkg::RX_IDLE;
                rx_move = 1'b1;
                if (!st_ff.rx_m2) begin
                  nxt_st.fer = 1'b1;
                end
                // Parity sense shared with transmit
                if (par_on(st_ff.fmt) && (st_ff.rx_par ^ st_ff.fmt[`FMT_ODD])) begin
                  nxt_st.per = 1'b1;
                end
              end
            end
          end
        end
        default: nxt_st.rx_st = serial_unit_pkg::RX_IDLE;
      endcase
    end
    // Hand the byte over unless the holding is still full
    if (rx_move) begin
      if (st_ff.rxf) begin
        nxt_st.orer = 1'b1;
      end else begin
        nxt_st.rxh = nxt_st.rx_sh;
        nxt_st.rxf = 1'b1; // Set wins over a clear
      end
    end
    // Standby returns everything to reset values
    if (standby) begin
      nxt_st = CORE_RST;
    end
  end

  // Single state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= CORE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign rdata = st_ff.rdata;
  assign txd = st_ff.txd;
  assign sck_out = st_ff.sck;
  assign tx_holding_empty_flag = st_ff.txe;
  assign rx_holding_full_flag = st_ff.rxf;

  // Checks
  chk_txe_on_load: assert property (@(posedge clk) disable iff (rst)
    tx_load && !standby |=> st_ff.txe) else $error("holding empty not set on load");
  chk_load_needs_clear: assert property (@(posedge clk) disable iff (rst)
    tx_load |-> !st_ff.txe && st_ff.ten) else $error("load with empty flag set");
  chk_rxf_on_move: assert property (@(posedge clk) disable iff (rst)
    rx_move && !st_ff.rxf && !standby |=> st_ff.rxf && st_ff.rxh == $past(nxt_st.rx_sh))
    else $error("receive move lost");
  chk_rx_seven_bit: assert property (@(posedge clk) disable iff (rst)
    rx_move && len == 4'h7 && !st_ff.rxf |=> !st_ff.rxh[7]) else $error("bit 7 not zero");
  chk_standby_values: assert property (@(posedge clk) disable iff (rst)
    standby |=> st_ff.rxh == 8'h00 && st_ff.txh == 8'hFF && st_ff.fmt == 8'h00)
    else $error("standby values wrong");
  chk_async_start_bit: assert property (@(posedge clk) disable iff (rst)
    tx_load && !st_ff.fmt[7] && !standby |=> !txd && st_ff.tx_left >= 4'h9)
    else $error("async frame lacks start bit");
  chk_sync_eight_bits: assert property (@(posedge clk) disable iff (rst)
    tx_load && st_ff.fmt[7] && !standby |=> st_ff.tx_left == 4'h8 && !sck_out)
    else $error("sync frame not eight bits");
  chk_back_to_back: assert property (@(posedge clk) disable iff (rst)
    tx_fin && st_ff.ten && !st_ff.txe |-> tx_load) else $error("gap between frames");
  chk_clear_starts: assert property (@(posedge clk) disable iff (rst)
    wr && addr == `OFS_FLAG && !wdata[7] && st_ff.ten && st_ff.txe && st_ff.tx_st == serial_unit_pkg::TX_IDLE
    && !standby |=> tx_load) else $error("clear did not start send");
  cov_async_load: cover property (@(posedge clk) tx_load && !st_ff.fmt[7]);
  cov_sync_load: cover property (@(posedge clk) tx_load && st_ff.fmt[7]);
  cov_rx_move: cover property (@(posedge clk) rx_move && !st_ff.rxf);
  cov_overrun: cover property (@(posedge clk) rx_move && st_ff.rxf);
endmodule

// [tb/serial_peer.sv]
/*
 Serial peer model: async frame sender and receiver, sync partner.
 Assumes the unit's clk and pins; rxd idles high as on a pulled-up line.
*/
`timescale 1ns/10ps
module serial_peer (
  input wire logic clk,
  input wire logic txd,
  input wire logic sck_out,
  output logic rxd
);
  // Idle line level
  initial rxd = 1'h1;

  // Start bit, then n frame bits of bit_clks clocks each
  task automatic send_frame(input logic [23:0] bits, input int n, input int bit_clks);
    @(posedge clk) rxd <= 1'h0;
    repeat (bit_clks) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (bit_clks) @(posedge clk);
    end
    rxd <= 1'h1; // Released line returns high
  endtask

  // Capture n bits after the start bit, each at mid-bit
  task automatic recv_frame(input int n, input int bit_clks, output logic [23:0] bits);
    bits = 24'h0;
    @(negedge txd);
    repeat (bit_clks / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (bit_clks) @(posedge clk);
      bits[i] = txd;
    end
  endtask

  // Sync partner: new bit after each clock fall, capture on rise
  task automatic sync_xfer(input logic [7:0] out, output logic [7:0] got);
    rxd <= out[0];
    for (int i = 0; i < 8; i++) begin
      @(posedge sck_out) got[i] = txd;
      if (i < 7) @(negedge sck_out) rxd <= out[i + 1];
    end
    repeat (4) @(posedge clk);
    rxd <= 1'h1; // Released line returns to its pulled-up idle level
  endtask
endmodule

// [tb/serial_unit_tb.sv]
/*
 Self-checking bench of the serial unit: register port, async frames
 both ways, back-to-back send, sync transfer, standby.
 Assumes the serial peer model and a 50 MHz clock.
*/
`timescale 1ns/10ps
module serial_unit_tb;
  logic clk = 1'h0; // 20 ns period
  logic rst = 1'h1; // Held 6 cycles
  logic standby = 1'h0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [7:0] rdata;
  logic rxd;
  logic txd;
  logic sck_out;
  logic tx_holding_empty_flag;
  logic rx_holding_full_flag;
  int num_errors = 0;
  int check_count = 0;
  logic [7:0] rv; // Last read value
  logic [23:0] exp_bits;
  logic [23:0] got_bits;
  // Async rows: format and data
  typedef struct packed {logic [7:0] fmt; logic [7:0] data;} row_type;
  row_type rows [9] = '{'{8'h00, 8'hA5}, '{8'h40, 8'hC3}, '{8'h20, 8'hB1}, '{8'h30, 8'hB1},
    '{8'h28, 8'h0F}, '{8'h34, 8'h5A}, '{8'h5C, 8'hE6}, '{8'h01, 8'h6E}, '{8'h12, 8'h99}};

  // Clock generator
  always #10 clk = ~clk;

  serial_unit #(.BIT_DIV(8'h01)) DUT (.clk(clk), .rst(rst), .standby(standby), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd), .sck_out(sck_out),
    .tx_holding_empty_flag(tx_holding_empty_flag), .rx_holding_full_flag(rx_holding_full_flag));
  serial_peer peer (.clk(clk), .txd(txd), .sck_out(sck_out), .rxd(rxd));

  // Compare and count
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] expd);
    check_count++;
    if (seen !== expd) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, expd, seen);
    end
  endtask

  // One-cycle register write
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask

  // Bounded wait for the receive-full flag
  task automatic wait_rxf();
    int k;
    k = 0;
    while (rx_holding_full_flag !== 1'h1 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    check("rx full", rx_holding_full_flag, 1'h1);
  endtask

  // Frame bits after the start bit; returns their count
  function automatic int build(input logic [7:0] f, input logic [7:0] d, output logic [23:0] b);
    int n;
    n = f[6] ? 7 : 8;
    b = 24'h0;
    for (int i = 0; i < n; i++) b[i] = d[i]; // LSB first, bit 7 dropped for seven bits
    if (f[2]) begin
      b[n] = 1'h1; // Multiprocessor bit from ctrl bit 0
      n++;
    end else if (f[5]) begin
      b[n] = ^(d & (f[6] ? 8'h7F : 8'hFF)) ^ f[4];
      n++;
    end
    b[n] = 1'h1; // Stop bits
    b[n + 1] = f[3];
    return n + (f[3] ? 2 : 1);
  endfunction

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    int n;
    int bc;
    logic seen_low;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    reg_rd(3'h0, rv);
    check("format reset", rv, 8'h00);
    reg_rd(3'h3, rv);
    check("tx holding reset", rv, 8'hFF);
    check("idle pins", {txd, sck_out, tx_holding_empty_flag, rx_holding_full_flag}, 4'hE);
    reg_wr(3'h5, 8'h5A);
    reg_rd(3'h5, rv);
    check("rx holding read only", rv, 8'h00);
    reg_rd(3'h7, rv);
    check("unmapped read", rv, 8'h00);
    reg_wr(3'h2, 8'h31);
    reg_wr(3'h3, 8'h55);
    reg_rd(3'h3, rv);
    check("tx holding rw", rv, 8'h55);
    seen_low = 1'h0;
    repeat (300) begin
      @(posedge clk);
      seen_low |= (txd !== 1'h1);
    end
    check("no send while empty", seen_low, 1'h0);
    // Full duplex async rows
    foreach (rows[r]) begin
      n = build(rows[r].fmt, rows[r].data, exp_bits);
      bc = (4 << (2 * rows[r].fmt[1:0])) * 16; // Bit time in clocks
      reg_wr(3'h0, rows[r].fmt);
      reg_rd(3'h0, rv);
      check("format rw", rv, rows[r].fmt);
      reg_wr(3'h3, rows[r].data);
      fork
        peer.recv_frame(n, bc, got_bits);
        peer.send_frame(exp_bits, n, bc);
        reg_wr(3'h4, 8'h7F); // Clear holding-empty to start
      join
      check("tx frame", got_bits, exp_bits);
      check("tx empty after load", tx_holding_empty_flag, 1'h1);
      wait_rxf();
      reg_rd(3'h5, rv);
      check("rx byte", rv, rows[r].data & (rows[r].fmt[6] ? 8'h7F : 8'hFF));
      reg_wr(3'h4, 8'h80);
    end
    // Second byte written during shifting
    reg_wr(3'h0, 8'h00);
    reg_wr(3'h3, 8'h3C);
    fork
      peer.recv_frame(19, 64, got_bits);
      begin
        reg_wr(3'h4, 8'h7F);
        repeat (4) @(posedge clk);
        reg_wr(3'h3, 8'hC5);
        reg_wr(3'h4, 8'h7F);
      end
    join
    check("back to back", got_bits, {5'h0, 1'h1, 8'hC5, 1'h0, 1'h1, 8'h3C});
    // Start right after a single stop while two are set
    reg_wr(3'h0, 8'h08);
    fork
      peer.send_frame({4'h0, 2'h3, 8'h96, 1'h0, 1'h1, 8'h69}, 20, 64);
      begin
        wait_rxf();
        reg_rd(3'h5, rv);
        check("rx first", rv, 8'h69);
        reg_wr(3'h4, 8'h80);
      end
    join
    wait_rxf();
    reg_rd(3'h5, rv);
    check("rx after one stop", rv, 8'h96);
    // Wrong parity still moves the byte and flags it
    reg_wr(3'h4, 8'h80);
    reg_wr(3'h0, 8'h20);
    peer.send_frame({14'h0, 1'h1, 1'h1, 8'hB1}, 10, 64);
    wait_rxf();
    reg_rd(3'h4, rv);
    check("parity error", rv & 8'h48, 8'h48);
    // Sync mode with every async-only bit set
    reg_wr(3'h4, 8'h80);
    reg_wr(3'h0, 8'hFC);
    reg_wr(3'h3, 8'hA7);
    fork
      peer.sync_xfer(8'h3B, rv);
      reg_wr(3'h4, 8'h7F);
    join
    check("sync tx", rv, 8'hA7);
    wait_rxf();
    reg_rd(3'h5, rv);
    check("sync rx", rv, 8'h3B);
    // Standby returns registers to reset values
    reg_wr(3'h0, 8'h5A);
    reg_wr(3'h3, 8'h12);
    @(posedge clk) standby <= 1'h1;
    @(posedge clk) standby <= 1'h0;
    reg_rd(3'h0, rv);
    check("format standby", rv, 8'h00);
    reg_rd(3'h3, rv);
    check("tx holding standby", rv, 8'hFF);
    reg_rd(3'h5, rv);
    check("rx holding standby", rv, 8'h00);
    tally_and_finish();
  end
endmodule
